// file: design/otg_defines.svh
// Offsets, field positions and reset values of the global register bank.
// Assumes inclusion by bare name from package and design files.
`ifndef OTG_DEFINES_SVH
`define OTG_DEFINES_SVH
`define OTG_IDX_GTC1 8'hf0
`define OTG_IDX_GFC 8'hf1
`define OTG_IDX_GTC2 8'hf2
`define OTG_IDX_GCLK 8'hf3
`define OTG_IDX_RSVA 8'hf4
`define OTG_IDX_LSRST 8'hf5
`define OTG_IDX_FSRST 8'hf6
`define OTG_IDX_RSVB 8'hf7
`define OTG_IDX_DEVID 8'hf8
`define OTG_IDX_FISUM 8'hf9
`define OTG_IDX_BISUM 8'hfa
`define OTG_IDX_LISUM 8'hfb
`define OTG_IDX_FIMSK 8'hfc
`define OTG_IDX_BIMSK 8'hfd
`define OTG_IDX_LIMSK 8'hfe
`define OTG_IDX_CAPEN 8'hff
`define OTG_BIT_LOSSSEL 5
`define OTG_BIT_WIREOR 4
`define OTG_BIT_BCAST 2
`define OTG_BIT_CAPTRIG 1
`define OTG_BIT_INTINH 0
`define OTG_GTC1_WMASK 8'h37
`define OTG_RST_REG 8'h00
`endif

// file: design/otg_pkg.sv
// Types shared by the global register bank.
// Assumes otg_defines.svh is on the include path.
package otg_pkg;
  typedef logic [7:0] otg_byte_t;
  typedef logic [7:0] otg_port_mask_t;
endpackage

// file: design/otg_global_regs.sv
// Global control and summary register bank of an eight-port transceiver.
// Assumes APB master on mclk, port units on mclk, summaries from same domain.
`timescale 1ns/1ps
`default_nettype none
`include "otg_defines.svh"
module otg_global_regs
  import otg_pkg::*;
#(
  parameter int NPORTS = 8,
  parameter logic [7:0] DEVICE_ID = 8'h5a // Arbitrary value
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Port-unit write request from the processor port
  input wire logic portWrReq,
  input wire logic [2:0] portWrSel,
  output logic [NPORTS-1:0] portWrEn,
  // Per-port status sources
  input wire logic [NPORTS-1:0] rxFrameLoss,
  input wire logic [NPORTS-1:0] txClockLoss,
  input wire logic [NPORTS-1:0] framerIrq,
  input wire logic [NPORTS-1:0] testerIrq,
  input wire logic [NPORTS-1:0] lineIrq,
  output logic [NPORTS-1:0] frameOrTxClockLossPin,
  output logic interleaveWireOrSelect,
  output logic [NPORTS-1:0] counterCapture,
  output logic [NPORTS-1:0] lineUnitSoftReset,
  output logic [NPORTS-1:0] framerTesterSoftReset,
  output logic [7:0] clockControl,
  output logic [7:0] framerControl,
  output logic [7:0] transceiverControl2,
  output logic interruptOutput_n
);
  initial begin
    if (NPORTS != 8) $error("otg_global_regs serves exactly eight ports");
  end

  otg_byte_t gtc1_r, gfc_r, gtc2_r, gclk_r, lsrst_r, fsrst_r;
  otg_byte_t fimsk_r, bimsk_r, limsk_r;
  otg_port_mask_t capEn_r;
  otg_port_mask_t capture_r;
  logic trigPrev_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [NPORTS-1:0] lossPin_r;
  logic intOut_n_r;
  logic [7:0] wIdx;
  logic wrAcc, rdAcc, mapped;
  otg_byte_t wByte;

  assign pready = 1'b1;
  assign wIdx = paddr[9:2];
  assign wByte = pstrb[0] ? pwdata[7:0] : 8'h00;
  assign wrAcc = psel && penable && pwrite && pstrb[0];
  assign rdAcc = psel && penable && !pwrite;

  // Only the global words of the first framer space decode; others answer with an error
  always_comb begin
    if (wIdx >= `OTG_IDX_GTC1 && paddr[31:10] == 22'h000000 && paddr[1:0] == 2'h0) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // Control registers; reserved words read zero and ignore writes
  always_ff @(posedge mclk) begin
    if (reset) begin
      gtc1_r <= `OTG_RST_REG;
      gfc_r <= `OTG_RST_REG;
      gtc2_r <= `OTG_RST_REG;
      gclk_r <= `OTG_RST_REG;
      lsrst_r <= `OTG_RST_REG;
      fsrst_r <= `OTG_RST_REG;
      fimsk_r <= `OTG_RST_REG;
      bimsk_r <= `OTG_RST_REG;
      limsk_r <= `OTG_RST_REG;
      capEn_r <= `OTG_RST_REG;
    end else if (wrAcc && mapped) begin
      if (wIdx == `OTG_IDX_GTC1) begin
        gtc1_r <= wByte & `OTG_GTC1_WMASK;
      end else if (wIdx == `OTG_IDX_GFC) begin
        gfc_r <= wByte;
      end else if (wIdx == `OTG_IDX_GTC2) begin
        gtc2_r <= wByte;
      end else if (wIdx == `OTG_IDX_GCLK) begin
        gclk_r <= wByte;
      end else if (wIdx == `OTG_IDX_LSRST) begin
        lsrst_r <= wByte;
      end else if (wIdx == `OTG_IDX_FSRST) begin
        fsrst_r <= wByte;
      end else if (wIdx == `OTG_IDX_FIMSK) begin
        fimsk_r <= wByte;
      end else if (wIdx == `OTG_IDX_BIMSK) begin
        bimsk_r <= wByte;
      end else if (wIdx == `OTG_IDX_LIMSK) begin
        limsk_r <= wByte;
      end else if (wIdx == `OTG_IDX_CAPEN) begin
        capEn_r <= wByte;
      end
    end
  end

  // Read mux
  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata_r <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      if (!mapped) begin
        prdata_r <= 32'h00000000;
      end else if (wIdx == `OTG_IDX_GTC1) begin
        prdata_r <= {24'h000000, gtc1_r};
      end else if (wIdx == `OTG_IDX_GFC) begin
        prdata_r <= {24'h000000, gfc_r};
      end else if (wIdx == `OTG_IDX_GTC2) begin
        prdata_r <= {24'h000000, gtc2_r};
      end else if (wIdx == `OTG_IDX_GCLK) begin
        prdata_r <= {24'h000000, gclk_r};
      end else if (wIdx == `OTG_IDX_LSRST) begin
        prdata_r <= {24'h000000, lsrst_r};
      end else if (wIdx == `OTG_IDX_FSRST) begin
        prdata_r <= {24'h000000, fsrst_r};
      end else if (wIdx == `OTG_IDX_DEVID) begin
        prdata_r <= {24'h000000, DEVICE_ID};
      end else if (wIdx == `OTG_IDX_FISUM) begin
        prdata_r <= {24'h000000, framerIrq};
      end else if (wIdx == `OTG_IDX_BISUM) begin
        prdata_r <= {24'h000000, testerIrq};
      end else if (wIdx == `OTG_IDX_LISUM) begin
        prdata_r <= {24'h000000, lineIrq};
      end else if (wIdx == `OTG_IDX_FIMSK) begin
        prdata_r <= {24'h000000, fimsk_r};
      end else if (wIdx == `OTG_IDX_BIMSK) begin
        prdata_r <= {24'h000000, bimsk_r};
      end else if (wIdx == `OTG_IDX_LIMSK) begin
        prdata_r <= {24'h000000, limsk_r};
      end else if (wIdx == `OTG_IDX_CAPEN) begin
        prdata_r <= {24'h000000, capEn_r};
      end else begin
        prdata_r <= 32'h00000000;
      end
    end
  end
  assign prdata = prdata_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      pslverr_r <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_r <= !mapped;
    end
  end
  assign pslverr = pslverr_r && psel && penable;

  // Broadcast fans one port write out to all eight ports alike
  always_comb begin
    portWrEn = '0;
    if (portWrReq) begin
      if (gtc1_r[`OTG_BIT_BCAST]) begin
        portWrEn = '1;
      end else begin
        portWrEn[portWrSel] = 1'b1;
      end
    end
  end

  // Only a fresh rising edge of the stored bit fires a capture
  always_ff @(posedge mclk) begin
    if (reset) begin
      trigPrev_r <= 1'b0;
      capture_r <= '0;
    end else begin
      trigPrev_r <= gtc1_r[`OTG_BIT_CAPTRIG];
      capture_r <= (gtc1_r[`OTG_BIT_CAPTRIG] && !trigPrev_r) ? capEn_r : '0;
    end
  end
  assign counterCapture = capture_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      lossPin_r <= '0;
    end else begin
      lossPin_r <= gtc1_r[`OTG_BIT_LOSSSEL] ? txClockLoss : rxFrameLoss;
    end
  end
  assign frameOrTxClockLossPin = lossPin_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      intOut_n_r <= 1'b1;
    end else begin
      intOut_n_r <= gtc1_r[`OTG_BIT_INTINH] ||
        !(|(framerIrq & fimsk_r) || |(testerIrq & bimsk_r) || |(lineIrq & limsk_r));
    end
  end
  assign interruptOutput_n = intOut_n_r;

  assign interleaveWireOrSelect = gtc1_r[`OTG_BIT_WIREOR];
  assign lineUnitSoftReset = lsrst_r;
  assign framerTesterSoftReset = fsrst_r;
  assign clockControl = gclk_r;
  assign framerControl = gfc_r;
  assign transceiverControl2 = gtc2_r;

  chk_loss_pin_select: assert property (@(posedge mclk) disable iff (reset)
    lossPin_r == $past(gtc1_r[`OTG_BIT_LOSSSEL] ? txClockLoss : rxFrameLoss))
    else $error("loss pin source wrong");
  chk_wire_or_mode: assert property (@(posedge mclk) disable iff (reset)
    interleaveWireOrSelect == gtc1_r[4])
    else $error("wire-or select wrong");
  chk_bcast_all_ports: assert property (@(posedge mclk) disable iff (reset)
    portWrReq && gtc1_r[2] |-> portWrEn == 8'hff)
    else $error("broadcast missed a port");
  chk_single_port_write: assert property (@(posedge mclk) disable iff (reset)
    portWrReq && !gtc1_r[2] |-> $onehot(portWrEn) && portWrEn[portWrSel])
    else $error("single port write wrong");
  sequence trigRise;
    !gtc1_r[1] ##1 gtc1_r[1];
  endsequence
  chk_capture_on_rise: assert property (@(posedge mclk) disable iff (reset)
    trigRise |=> counterCapture == $past(capEn_r) ##1 counterCapture == 8'h00)
    else $error("capture pulse wrong");
  chk_capture_enabled_only: assert property (@(posedge mclk) disable iff (reset)
    (counterCapture & ~$past(capEn_r)) == 8'h00)
    else $error("disabled framer captured");
  chk_irq_inhibit: assert property (@(posedge mclk) disable iff (reset)
    $past(gtc1_r[0]) |-> interruptOutput_n)
    else $error("inhibited interrupt asserted");
  chk_irq_assert: assert property (@(posedge mclk) disable iff (reset)
    !gtc1_r[0] && |(framerIrq & fimsk_r) |=> !interruptOutput_n)
    else $error("unmasked interrupt not shown");
  chk_devid_read: assert property (@(posedge mclk) disable iff (reset)
    psel && !penable && !pwrite && paddr == 32'h000003e0 |=> prdata == {24'h0, DEVICE_ID})
    else $error("device id read wrong");
  chk_summary_read: assert property (@(posedge mclk) disable iff (reset)
    psel && !penable && !pwrite && paddr == 32'h000003e4 |=> prdata[7:0] == $past(framerIrq))
    else $error("framer summary read wrong");
  chk_mask_write: assert property (@(posedge mclk) disable iff (reset)
    wrAcc && paddr == 32'h000003f0 |=> fimsk_r == $past(pwdata[7:0]))
    else $error("framer mask write lost");
  chk_reset_write: assert property (@(posedge mclk) disable iff (reset)
    wrAcc && paddr == 32'h000003d4 |=> lineUnitSoftReset == $past(pwdata[7:0]))
    else $error("line reset write lost");
  chk_ctrl1_reset: assert property (@(posedge mclk) $past(reset) |-> gtc1_r == 8'h00)
    else $error("control 1 not reset");

  // Bus answers: no wait states, errors only for words outside the bank
  chk_pready_high: assert property (@(posedge mclk) disable iff (reset)
    pready)
    else $error("ready dropped");
  chk_err_unmapped: assert property (@(posedge mclk) disable iff (reset)
    psel && penable |-> pslverr == !mapped)
    else $error("error flag wrong");
  chk_no_write_unmapped: assert property (@(posedge mclk) disable iff (reset)
    wrAcc && !mapped |=> $stable(gtc1_r) && $stable(capEn_r) && $stable(fimsk_r))
    else $error("unmapped write landed");

  // Control register 1 keeps unused bits clear from reset on
  chk_ctrl1_spare_bits: assert property (@(posedge mclk) disable iff (reset)
    (gtc1_r & 8'hc8) == 8'h00)
    else $error("spare control bits set");
  chk_outputs_reset: assert property (@(posedge mclk) $past(reset) |->
    lossPin_r == 8'h00 && intOut_n_r && capture_r == 8'h00)
    else $error("outputs not reset");
  chk_wire_or_reset: assert property (@(posedge mclk) $past(reset) |->
    !interleaveWireOrSelect)
    else $error("wire-or not cleared by reset");

  // Summary, mask and soft reset words, one word at a time
  chk_tester_sum_read: assert property (@(posedge mclk) disable iff (reset)
    psel && !penable && !pwrite && paddr == 32'h000003e8 |=> prdata[7:0] == $past(testerIrq))
    else $error("tester summary read wrong");
  chk_line_sum_read: assert property (@(posedge mclk) disable iff (reset)
    psel && !penable && !pwrite && paddr == 32'h000003ec |=> prdata[7:0] == $past(lineIrq))
    else $error("line summary read wrong");
  chk_tester_mask_write: assert property (@(posedge mclk) disable iff (reset)
    wrAcc && paddr == 32'h000003f4 |=> bimsk_r == $past(pwdata[7:0]))
    else $error("tester mask write lost");
  chk_line_mask_write: assert property (@(posedge mclk) disable iff (reset)
    wrAcc && paddr == 32'h000003f8 |=> limsk_r == $past(pwdata[7:0]))
    else $error("line mask write lost");
  chk_framer_reset_write: assert property (@(posedge mclk) disable iff (reset)
    wrAcc && paddr == 32'h000003d8 |=> framerTesterSoftReset == $past(pwdata[7:0]))
    else $error("framer reset write lost");

  // Interrupt pin follows every unit type, one cycle behind
  chk_irq_tester: assert property (@(posedge mclk) disable iff (reset)
    !gtc1_r[0] && |(testerIrq & bimsk_r) |=> !interruptOutput_n)
    else $error("tester interrupt not shown");
  chk_irq_line: assert property (@(posedge mclk) disable iff (reset)
    !gtc1_r[0] && |(lineIrq & limsk_r) |=> !interruptOutput_n)
    else $error("line interrupt not shown");
  chk_irq_quiet: assert property (@(posedge mclk) disable iff (reset)
    !(|(framerIrq & fimsk_r) || |(testerIrq & bimsk_r) || |(lineIrq & limsk_r)) |=> interruptOutput_n)
    else $error("interrupt without cause");

  // Port writes only move when asked for
  chk_wren_idle: assert property (@(posedge mclk) disable iff (reset)
    !portWrReq |-> portWrEn == 8'h00)
    else $error("port write without request");

  // A held trigger bit must not fire again; enables land where written
  chk_capture_held: assert property (@(posedge mclk) disable iff (reset)
    gtc1_r[1] && $past(gtc1_r[1]) |=> counterCapture == 8'h00)
    else $error("held trigger captured again");
  chk_capture_cause: assert property (@(posedge mclk) disable iff (reset)
    counterCapture != 8'h00 |-> $past(gtc1_r[1]) && !$past(trigPrev_r))
    else $error("capture without rising trigger");
  chk_capen_write: assert property (@(posedge mclk) disable iff (reset)
    wrAcc && paddr == 32'h000003fc |=> capEn_r == $past(pwdata[7:0]))
    else $error("capture enable write lost");
endmodule
`default_nettype wire

// file: testbench/otg_global_regs_tb.sv
// Self-checking bench for the global register bank, with a register model.
// Assumes the design package and module are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module otg_global_regs_tb;
  import otg_pkg::*;
  localparam logic [7:0] DEV_ID = 8'h3c; // Arbitrary value
  logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, portWrReq = 0;
  logic [31:0] paddr = 0, pwdata = 0;
  logic [3:0] pstrb = 0;
  logic [2:0] portWrSel = 0;
  logic [7:0] rxFrameLoss = 0, txClockLoss = 0, framerIrq = 0, testerIrq = 0, lineIrq = 0;
  logic pready, pslverr, interruptOutput_n, interleaveWireOrSelect, lowA;
  logic [31:0] prdata;
  logic [7:0] portWrEn, frameOrTxClockLossPin, counterCapture, lineUnitSoftReset, capEn;
  logic [7:0] framerTesterSoftReset, clockControl, framerControl, transceiverControl2;
  int err_count = 0, samples_checked = 0, seed = 32'hd51d, pulses = 0, mdl [256];
  logic [7:0] rwIdx[$] = '{8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'hf5, 8'hf6, 8'hfc, 8'hfd, 8'hfe, 8'hff};
  otg_global_regs #(.NPORTS(8), .DEVICE_ID(DEV_ID)) otg_global_regs_inst (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .portWrReq(portWrReq), .portWrSel(portWrSel), .portWrEn(portWrEn),
    .rxFrameLoss(rxFrameLoss), .txClockLoss(txClockLoss), .framerIrq(framerIrq),
    .testerIrq(testerIrq), .lineIrq(lineIrq), .frameOrTxClockLossPin(frameOrTxClockLossPin),
    .interleaveWireOrSelect(interleaveWireOrSelect), .counterCapture(counterCapture),
    .lineUnitSoftReset(lineUnitSoftReset), .framerTesterSoftReset(framerTesterSoftReset),
    .clockControl(clockControl), .framerControl(framerControl),
    .transceiverControl2(transceiverControl2), .interruptOutput_n(interruptOutput_n));
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] expv(input logic [7:0] i);
    case (i)
      8'hf8: return {24'h0, DEV_ID};
      8'hf9: return {24'h0, framerIrq};
      8'hfa: return {24'h0, testerIrq};
      8'hfb: return {24'h0, lineIrq};
      default: return (i < 8'hf0) ? 32'h0 : 32'(mdl[i]);
    endcase
  endfunction
  // Host write masks: reserved words get zeros, broadcast stays off around reads
  function automatic logic [7:0] wmask(input logic [7:0] i);
    return (i == 8'hf4 || i == 8'hf7) ? 8'h00 : (i == 8'hf0) ? 8'hfb : 8'hff;
  endfunction
  // Called just after a rising edge; every read is checked against the model
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= ({$random(seed)} << 8) | {24'h0, d};
    pstrb <= 4'h1;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge mclk);
    end
    chk("pready", {31'h0, pready}, 32'h1);
    if (!wr) chk("prdata", prdata, expv(idx));
    chk("pslverr", {31'h0, pslverr}, {31'h0, idx < 8'hf0});
    if (wr && (idx inside {rwIdx})) mdl[idx] = d & ((idx == 8'hf0) ? 8'h37 : 8'hff);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  // Registered one-cycle pulses are counted away from the launching edge
  always @(negedge mclk) begin
    if (counterCapture !== 8'h00) pulses++;
    if (counterCapture !== 8'h00) chk("capture", {24'h0, counterCapture}, 32'(mdl[255][7:0]));
  end
  initial begin
    #(25ns * 20000);
    err_count++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    for (int i = 240; i < 256; i++) apb(0, i[7:0], 8'h0);
    $display("test reset values done");
    for (int r = 0; r < 3; r++) begin
      framerIrq <= 8'($random(seed));
      testerIrq <= 8'($random(seed));
      lineIrq <= 8'($random(seed));
      for (int i = 240; i < 256; i++) apb(1, i[7:0], 8'($random(seed)) & wmask(i[7:0]));
      apb(1, 8'h20, 8'h00);
      for (int i = 238; i < 256; i++) apb(0, i[7:0], 8'h0);
      wt(0);
      chk("lsrst", {24'h0, lineUnitSoftReset}, mdl[8'hf5]);
      chk("fsrst", {24'h0, framerTesterSoftReset}, mdl[8'hf6]);
      chk("ctl", {clockControl, framerControl, transceiverControl2}, {mdl[8'hf3][7:0],
        mdl[8'hf1][7:0], mdl[8'hf2][7:0]});
      @(posedge mclk);
    end
    $display("test register access done");
    for (int s = 0; s < 2; s++) begin
      apb(1, 8'hf0, 8'(s * 8'h30));
      rxFrameLoss <= 8'($random(seed));
      txClockLoss <= 8'($random(seed));
      wt(2);
      chk("losspin", {24'h0, frameOrTxClockLossPin}, {24'h0, s ? txClockLoss : rxFrameLoss});
      chk("wireor", {31'h0, interleaveWireOrSelect}, s);
      @(posedge mclk);
    end
    $display("test pin select done");
    for (int b = 0; b < 2; b++) begin
      apb(1, 8'hf0, 8'(b * 4));
      for (int p = 0; p < 8; p++) begin
        portWrReq <= 1'b1;
        portWrSel <= p[2:0];
        wt(1);
        chk("portwren", {24'h0, portWrEn}, b ? 32'hff : 32'h1 << p);
      end
      @(posedge mclk);
    end
    portWrReq <= 1'b0;
    $display("test broadcast done");
    capEn = (8'($random(seed)) & 8'h7e) | 8'h01;
    apb(1, 8'hf0, 8'h00);
    apb(1, 8'hff, capEn);
    wt(2);
    pulses = 0;
    @(posedge mclk);
    foreach (rwIdx[k]) apb(1, 8'hf0, (k % 3 == 0) ? 8'h00 : 8'h02);
    wt(2);
    chk("pulses", pulses, 3);
    @(posedge mclk);
    $display("test capture done");
    framerIrq <= 8'hff;
    testerIrq <= 8'hff;
    lineIrq <= 8'hff;
    for (int m = 0; m < 2; m++) begin
      for (int i = 252; i < 255; i++) apb(1, i[7:0], 8'(m * 8'hff));
      apb(1, 8'hf0, 8'h00);
      wt(2);
      if (m == 0) lowA = interruptOutput_n === 1'b0;
      chk("irqlevel", {31'h0, interruptOutput_n}, m ? 32'h0 : 32'h1);
      @(posedge mclk);
    end
    chk("maskeffect", {31'h0, lowA ^ (interruptOutput_n === 1'b0)}, 32'h1);
    apb(1, 8'hf0, 8'h01);
    apb(1, 8'hfc, 8'h00);
    wt(2);
    chk("inhibit", {31'h0, interruptOutput_n}, 32'h1);
    $display("test interrupt pin done");
    end_sim();
  end
endmodule
`default_nettype wire
